/* File: shared/i2c_status_fifo_level_pkg.sv */
// Constants for the FIFO status and fill-level register block.
//
// Contract
// - Status register readable anytime, read-only, none of its bits raise interrupts.
// - Disable forces tx-not-full and tx-empty to one, rx flags to zero.
// - Disabled with state machines idle clears master and slave activity flags.
// - Slave activity bit 6 is set while slave machine is not idle.
// - Master activity bit 5 is set while master machine is not idle.
// - Activity bit 0 is the OR of master and slave activity.
// - Receive-full bit 4 set when every receive location is occupied.
// - Receive-not-empty bit 3 set while receive FIFO holds an entry.
// - Transmit-empty bit 2 set when transmit FIFO is empty; resets to one.
// - Transmit-not-full bit 1 set while a location is free; status resets to six.
// - Transmit fill count in bits 4:0, up on push, down on pop.
// - Transmit count zeroed on disable, raw transmit abort, or slave bulk abort.
// - Receive fill count in bits 4:0, up on store, down on removal.
// - Receive count zeroed on disable or any recorded transmit abort cause.
// - Clearing enable flushes both FIFOs; both stay empty while disabled.
package i2c_status_fifo_level_pkg;

  // ---------------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------------
  localparam int unsigned ADR_W             = 32;
  localparam int unsigned DAT_W             = 32;
  localparam logic [31:0] STATUS_ADDR       = 32'hB000_2870;
  localparam logic [31:0] TX_FILL_ADDR      = 32'hB000_2874;
  localparam logic [31:0] RX_FILL_ADDR      = 32'hB000_2878;
  localparam logic [31:0] EVENT_STATUS_ADDR = 32'hB000_28F0;
  localparam logic [31:0] EVENT_MASK_ADDR   = 32'hB000_28F4;

  // ---------------------------------------------------------------------
  // Status register field positions
  // ---------------------------------------------------------------------
  localparam int unsigned ACTIVITY_BIT       = 0;
  localparam int unsigned TX_NOT_FULL_BIT    = 1;
  localparam int unsigned TX_EMPTY_BIT       = 2;
  localparam int unsigned RX_NOT_EMPTY_BIT   = 3;
  localparam int unsigned RX_FULL_BIT        = 4;
  localparam int unsigned INITIATOR_BUSY_BIT = 5;
  localparam int unsigned TARGET_BUSY_BIT    = 6;

  // ---------------------------------------------------------------------
  // FIFO geometry and reset values
  // ---------------------------------------------------------------------
  localparam int unsigned FILL_W      = 5;
  localparam logic [4:0]  FIFO_DEPTH  = 5'h10;
  localparam logic [4:0]  FILL_RST    = 5'h00;
  localparam logic [31:0] STATUS_RST  = 32'h0000_0006;

  // ---------------------------------------------------------------------
  // Event status and mask layout
  // ---------------------------------------------------------------------
  localparam int unsigned EVT_W           = 4;
  localparam int unsigned TX_OVERFLOW_BIT  = 0;
  localparam int unsigned RX_OVERFLOW_BIT  = 1;
  localparam int unsigned TX_UNDERFLOW_BIT = 2;
  localparam int unsigned RX_UNDERFLOW_BIT = 3;
  localparam logic [3:0]  EVT_RST          = 4'h0;
  localparam logic [3:0]  MASK_RST         = 4'h0;

endpackage : i2c_status_fifo_level_pkg

/* File: design/i2c_status_fifo_level.sv */
// FIFO status and fill-level registers behind a classic Wishbone slave.
`timescale 1ns/1ps
`default_nettype none

module i2c_status_fifo_level (
  input  wire logic                                    clk_sys_i,
  input  wire logic                                    rst_n_i,
  input  wire logic                                    wb_cyc_i,
  input  wire logic                                    wb_stb_i,
  input  wire logic                                    wb_we_i,
  input  wire logic [i2c_status_fifo_level_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                              wb_sel_i,
  input  wire logic [i2c_status_fifo_level_pkg::DAT_W-1:0] wb_dat_i,
  output var  logic [i2c_status_fifo_level_pkg::DAT_W-1:0] wb_dat_o,
  output var  logic                                    wb_ack_o,
  input  wire logic                                    controller_on_flag_i,
  input  wire logic                                    tx_push_i,
  input  wire logic                                    tx_pop_i,
  input  wire logic                                    rx_push_i,
  input  wire logic                                    rx_pop_i,
  input  wire logic                                    transmit_abort_event_i,
  input  wire logic                                    slave_bulk_abort_i,
  input  wire logic                                    abort_cause_any_i,
  input  wire logic                                    initiator_idle_i,
  input  wire logic                                    target_idle_i,
  output var  logic                                    irq_o
);

  import i2c_status_fifo_level_pkg::*;

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [4:0]  tx_cnt;
    logic [4:0]  rx_cnt;
    logic        initiator_busy;
    logic        target_busy;
    logic [3:0]  evt;
    logic [3:0]  mask;
    logic        ack;
    logic [31:0] dat;
    logic        irq;
  } state_t;

  localparam state_t STATE_RST = '{
    tx_cnt:         FILL_RST,
    rx_cnt:         FILL_RST,
    initiator_busy: 1'b0,
    target_busy:    1'b0,
    evt:            EVT_RST,
    mask:           MASK_RST,
    ack:            1'b0,
    dat:            32'h0000_0000,
    irq:            1'b0
  };

  state_t state_q;
  state_t state_d;

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  // A push and a pop in the same cycle cancel, even at the limits, so the
  // count never wraps; a lone push at full or pop at empty is dropped.
  function automatic logic [4:0] next_count(input logic [4:0] cnt,
                                            input logic       push,
                                            input logic       pop,
                                            input logic       clr);
    logic [4:0] n;
    n = cnt;
    if (clr) begin
      n = FILL_RST;
    end else if (push && !pop && cnt != FIFO_DEPTH) begin
      n = cnt + 5'h01;
    end else if (pop && !push && cnt != 5'h00) begin
      n = cnt - 5'h01;
    end
    return n;
  endfunction : next_count

  // FIFO flags come from the counters alone, so they always match the levels.
  function automatic logic [31:0] status_word(input logic [4:0] tx,
                                              input logic [4:0] rx,
                                              input logic       ini,
                                              input logic       tgt);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[ACTIVITY_BIT]       = ini | tgt;
    w[TX_NOT_FULL_BIT]    = (tx != FIFO_DEPTH);
    w[TX_EMPTY_BIT]       = (tx == 5'h00);
    w[RX_NOT_EMPTY_BIT]   = (rx != 5'h00);
    w[RX_FULL_BIT]        = (rx == FIFO_DEPTH);
    w[INITIATOR_BUSY_BIT] = ini;
    w[TARGET_BUSY_BIT]    = tgt;
    return w;
  endfunction : status_word

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------
  logic       req;
  logic       tx_clr;
  logic       rx_clr;
  logic [3:0] evt_set;
  logic [3:0] evt_clr;

  always_comb begin
    state_d = state_q;

    // Disable flushes both FIFOs and holds them empty.
    tx_clr = !controller_on_flag_i || transmit_abort_event_i ||
             slave_bulk_abort_i;
    rx_clr = !controller_on_flag_i || abort_cause_any_i;

    state_d.tx_cnt = next_count(state_q.tx_cnt, tx_push_i, tx_pop_i,
                                tx_clr);
    state_d.rx_cnt = next_count(state_q.rx_cnt, rx_push_i, rx_pop_i,
                                rx_clr);

    // The busy flags follow the machines; once disabled they drop as soon
    // as the machines report idle.
    state_d.initiator_busy = !initiator_idle_i;
    state_d.target_busy    = !target_idle_i;

    // Error events on the FIFO strobes while enabled.
    evt_set = 4'h0;
    evt_set[TX_OVERFLOW_BIT]  = !tx_clr && tx_push_i && !tx_pop_i &&
                                state_q.tx_cnt == FIFO_DEPTH;
    evt_set[RX_OVERFLOW_BIT]  = !rx_clr && rx_push_i && !rx_pop_i &&
                                state_q.rx_cnt == FIFO_DEPTH;
    evt_set[TX_UNDERFLOW_BIT] = !tx_clr && tx_pop_i && !tx_push_i &&
                                state_q.tx_cnt == 5'h00;
    evt_set[RX_UNDERFLOW_BIT] = !rx_clr && rx_pop_i && !rx_push_i &&
                                state_q.rx_cnt == 5'h00;

    // Bus access: one wait cycle, ack for one cycle, then drop.
    req     = wb_cyc_i && wb_stb_i && !state_q.ack;
    evt_clr = 4'h0;
    state_d.ack = req;
    if (req && wb_we_i) begin
      // Status and level registers ignore writes.
      if (wb_adr_i == EVENT_STATUS_ADDR && wb_sel_i[0]) begin
        evt_clr = wb_dat_i[EVT_W-1:0];
      end
      if (wb_adr_i == EVENT_MASK_ADDR && wb_sel_i[0]) begin
        state_d.mask = wb_dat_i[EVT_W-1:0];
      end
    end
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        STATUS_ADDR: begin
          state_d.dat = status_word(state_q.tx_cnt, state_q.rx_cnt,
                                    state_q.initiator_busy,
                                    state_q.target_busy);
        end
        TX_FILL_ADDR: begin
          state_d.dat = {27'h000_0000, state_q.tx_cnt};
        end
        RX_FILL_ADDR: begin
          state_d.dat = {27'h000_0000, state_q.rx_cnt};
        end
        EVENT_STATUS_ADDR: begin
          state_d.dat = {28'h000_0000, state_q.evt};
        end
        EVENT_MASK_ADDR: begin
          state_d.dat = {28'h000_0000, state_q.mask};
        end
        default: begin
          state_d.dat = 32'h0000_0000;
        end
      endcase
    end

    // A new event wins over a clear in the same cycle.
    state_d.evt = (state_q.evt & ~evt_clr) | evt_set;
    // Only the event register, gated by the mask, feeds the interrupt, never the status word.
    state_d.irq = |(state_d.evt & state_d.mask);
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= STATE_RST;
    end else begin
      state_q <= state_d;
    end
  end

  assign wb_dat_o = state_q.dat;
  assign wb_ack_o = state_q.ack;
  assign irq_o    = state_q.irq;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  logic        tx_step_up;
  logic        rx_step_down;
  logic        tx_step_down;
  logic        rx_step_up;
  logic [31:0] status_now;
  assign tx_step_up   = controller_on_flag_i && !transmit_abort_event_i &&
                        !slave_bulk_abort_i && tx_push_i && !tx_pop_i &&
                        state_q.tx_cnt != FIFO_DEPTH;
  assign rx_step_down = controller_on_flag_i && !abort_cause_any_i &&
                        rx_pop_i && !rx_push_i && state_q.rx_cnt != 5'h00;
  assign tx_step_down = controller_on_flag_i && !transmit_abort_event_i &&
                        !slave_bulk_abort_i && tx_pop_i && !tx_push_i &&
                        state_q.tx_cnt != 5'h00;
  assign rx_step_up   = controller_on_flag_i && !abort_cause_any_i &&
                        rx_push_i && !rx_pop_i && state_q.rx_cnt != FIFO_DEPTH;
  assign status_now   = status_word(state_q.tx_cnt, state_q.rx_cnt,
                                    state_q.initiator_busy,
                                    state_q.target_busy);

  status_read_a: assert property (
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == STATUS_ADDR |->
      wb_dat_o == status_word($past(state_q.tx_cnt), $past(state_q.rx_cnt),
                              $past(state_q.initiator_busy),
                              $past(state_q.target_busy)))
    else $error("status read data does not match the counters");

  disable_flush_a: assert property (
    !controller_on_flag_i [*2] |=>
      state_q.tx_cnt == 5'h00 && state_q.rx_cnt == 5'h00 [*1])
    else $error("FIFO counts not held at zero while disabled");

  disable_flags_a: assert property (
    !controller_on_flag_i |=>
      status_word(state_q.tx_cnt, state_q.rx_cnt, 1'b0, 1'b0) == 32'h0000_0006)
    else $error("FIFO flags not forced on disable");

  tx_abort_clear_a: assert property (
    transmit_abort_event_i || slave_bulk_abort_i |=> state_q.tx_cnt == 5'h00)
    else $error("transmit count survived an abort");

  rx_abort_clear_a: assert property (
    abort_cause_any_i |=> state_q.rx_cnt == 5'h00)
    else $error("receive count survived an abort");

  tx_count_up_a: assert property (
    tx_step_up |=> state_q.tx_cnt == $past(state_q.tx_cnt) + 5'h01)
    else $error("transmit count did not step up on push");

  rx_count_down_a: assert property (
    rx_step_down |=> state_q.rx_cnt == $past(state_q.rx_cnt) - 5'h01)
    else $error("receive count did not step down on pop");

  target_busy_a: assert property (
    !target_idle_i |=> state_q.target_busy)
    else $error("slave activity flag wrong");

  target_idle_a: assert property (
    target_idle_i |=> !state_q.target_busy)
    else $error("slave activity flag set while idle");

  initiator_busy_a: assert property (
    !initiator_idle_i |=> state_q.initiator_busy)
    else $error("master activity flag wrong");

  initiator_idle_a: assert property (
    initiator_idle_i |=> !state_q.initiator_busy)
    else $error("master activity flag set while idle");

  idle_disabled_a: assert property (
    !controller_on_flag_i && initiator_idle_i && target_idle_i |=>
      !state_q.initiator_busy && !state_q.target_busy)
    else $error("activity flags not cleared when disabled and idle");

  rx_full_flag_a: assert property (
    rx_push_i && !rx_pop_i && !abort_cause_any_i && controller_on_flag_i &&
    state_q.rx_cnt == 5'h0F |=> status_now[RX_FULL_BIT])
    else $error("receive full flag missed");

  irq_gate_a: assert property (
    irq_o |-> |(state_q.evt & state_q.mask))
    else $error("interrupt without an unmasked event");

  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  ack_answer_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in the next cycle");

  tx_count_down_a: assert property (
    tx_step_down |=> state_q.tx_cnt == $past(state_q.tx_cnt) - 5'h01)
    else $error("transmit count did not step down on pop");

  rx_count_up_a: assert property (
    rx_step_up |=> state_q.rx_cnt == $past(state_q.rx_cnt) + 5'h01)
    else $error("receive count did not step up on store");

  tx_count_hold_a: assert property (
    controller_on_flag_i && !transmit_abort_event_i && !slave_bulk_abort_i &&
    tx_push_i == tx_pop_i |=> $stable(state_q.tx_cnt))
    else $error("transmit count moved without a strobe");

  rx_count_hold_a: assert property (
    controller_on_flag_i && !abort_cause_any_i && rx_push_i == rx_pop_i |=>
      $stable(state_q.rx_cnt))
    else $error("receive count moved without a strobe");

  tx_level_read_a: assert property (
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == TX_FILL_ADDR |->
      wb_dat_o == {27'h000_0000, $past(state_q.tx_cnt)})
    else $error("transmit level read data wrong");

  rx_level_read_a: assert property (
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == RX_FILL_ADDR |->
      wb_dat_o == {27'h000_0000, $past(state_q.rx_cnt)})
    else $error("receive level read data wrong");

  activity_read_a: assert property (
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == STATUS_ADDR |->
      wb_dat_o[ACTIVITY_BIT] ==
        (wb_dat_o[INITIATOR_BUSY_BIT] || wb_dat_o[TARGET_BUSY_BIT]))
    else $error("activity bit is not the OR of the busy bits");

  tx_flags_read_a: assert property (
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == STATUS_ADDR |->
      wb_dat_o[TX_EMPTY_BIT] == ($past(state_q.tx_cnt) == 5'h00) &&
      wb_dat_o[TX_NOT_FULL_BIT] == ($past(state_q.tx_cnt) != FIFO_DEPTH))
    else $error("transmit flags disagree with the transmit level");

  rx_flags_read_a: assert property (
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == STATUS_ADDR |->
      wb_dat_o[RX_NOT_EMPTY_BIT] == ($past(state_q.rx_cnt) != 5'h00) &&
      wb_dat_o[RX_FULL_BIT] == ($past(state_q.rx_cnt) == FIFO_DEPTH))
    else $error("receive flags disagree with the receive level");

  reserved_zero_a: assert property (
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == STATUS_ADDR |->
      wb_dat_o[31:7] == '0)
    else $error("reserved status bits not zero");

  overflow_event_a: assert property (
    controller_on_flag_i && !transmit_abort_event_i && !slave_bulk_abort_i &&
    tx_push_i && !tx_pop_i && state_q.tx_cnt == FIFO_DEPTH |=>
      state_q.evt[TX_OVERFLOW_BIT])
    else $error("transmit overflow event not recorded");

  status_read_c: cover property (
    wb_ack_o && $past(wb_adr_i) == STATUS_ADDR && wb_dat_o[TX_EMPTY_BIT]);
  tx_full_c: cover property (state_q.tx_cnt == FIFO_DEPTH);
  abort_flush_c: cover property (
    state_q.rx_cnt != 5'h00 ##1 abort_cause_any_i ##1 state_q.rx_cnt == 5'h00);
  irq_raise_c: cover property ($rose(irq_o));

endmodule : i2c_status_fifo_level

`default_nettype wire

/* File: verif/peer_model.sv */
// Far-side model: FIFO traffic from the bus side and state-machine idle levels.
`timescale 1ns/1ps
`default_nettype none

module peer_model (
  input  wire logic       clk_sys_i,
  output var  logic [4:0] strobe_o,
  output var  logic [1:0] idle_o
);
  // --------------------------------------------------------------------
  // Bus-side strobes and idle levels
  // --------------------------------------------------------------------
  // Strobe bits: 0 tx removal, 1 rx store, 2 raw abort, 3 bulk abort, 4 cause.
  // Idle bits: 0 initiator idle, 1 target idle.
  initial begin
    strobe_o = 5'h00;
    idle_o   = 2'h3;
  end

  task automatic pulse(input logic [4:0] v, input int n);
    @(posedge clk_sys_i);
    strobe_o <= v;
    repeat (n) @(posedge clk_sys_i);
    strobe_o <= 5'h00;
  endtask : pulse

  task automatic set_idle(input logic [1:0] v);
    @(posedge clk_sys_i);
    idle_o <= v;
  endtask : set_idle
endmodule : peer_model
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the FIFO status and fill-level registers.
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %h expected %h", $time, g, e); end end

module tb;
  import i2c_status_fifo_level_pkg::*;
  // --------------------------------------------------------------------
  // Signals, design and far side
  // --------------------------------------------------------------------
  logic        clk_sys_i   = 1'b0;
  logic        rst_n_i     = 1'b0;
  logic        cyc         = 1'b0;
  logic        stb         = 1'b0;
  logic        we          = 1'b0;
  logic [31:0] adr         = 32'h0000_0000;
  logic [31:0] wdat        = 32'h0000_0000;
  logic [3:0]  sel         = 4'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        irq;
  logic        en          = 1'b0;
  logic [1:0]  sw_q        = 2'h0;
  logic [4:0]  strobe;
  logic [1:0]  idle;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cycles      = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  i2c_status_fifo_level i_i2c_status_fifo_level (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .controller_on_flag_i(en),
    .tx_push_i(sw_q[0]), .tx_pop_i(strobe[0]), .rx_push_i(strobe[1]),
    .rx_pop_i(sw_q[1]), .transmit_abort_event_i(strobe[2]),
    .slave_bulk_abort_i(strobe[3]), .abort_cause_any_i(strobe[4]),
    .initiator_idle_i(idle[0]), .target_idle_i(idle[1]), .irq_o(irq));

  peer_model i_peer_model (.clk_sys_i(clk_sys_i), .strobe_o(strobe),
    .idle_o(idle));

  // --------------------------------------------------------------------
  // Bus and software-side tasks
  // --------------------------------------------------------------------
  task automatic wb(input logic w, input logic [31:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk_sys_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    sel  <= 4'hF;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (ack !== 1'b1);
    `CHK(k, 2)
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic chk_rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    `CHK(q, e)
  endtask : chk_rd

  task automatic sw(input logic [1:0] v, input int n);
    @(posedge clk_sys_i);
    sw_q <= v;
    repeat (n) @(posedge clk_sys_i);
    sw_q <= 2'h0;
  endtask : sw

  task automatic tdone(input string name);
    $display("test done: %s", name);
  endtask : tdone

  task automatic irq_is(input logic e);
    repeat (2) @(negedge clk_sys_i);
    `CHK(irq, e)
  endtask : irq_is

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  // A hang counts as a mismatch and still ends in the closing report.
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      summarize();
    end
  end

  // --------------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    chk_rd(STATUS_ADDR, 32'h0000_0006);
    chk_rd(TX_FILL_ADDR, 32'h0000_0000);
    chk_rd(RX_FILL_ADDR, 32'h0000_0000);
    tdone("reset");
    en <= 1'b1;
    sw(2'h1, 16);
    chk_rd(TX_FILL_ADDR, 32'h0000_0010);
    chk_rd(STATUS_ADDR, 32'h0000_0000);
    sw(2'h1, 1);
    chk_rd(TX_FILL_ADDR, 32'h0000_0010);
    i_peer_model.pulse(5'h01, 3);
    chk_rd(TX_FILL_ADDR, 32'h0000_000D);
    chk_rd(STATUS_ADDR, 32'h0000_0002);
    tdone("tx level");
    i_peer_model.pulse(5'h02, 16);
    chk_rd(RX_FILL_ADDR, 32'h0000_0010);
    chk_rd(STATUS_ADDR, 32'h0000_001A);
    sw(2'h2, 1);
    chk_rd(RX_FILL_ADDR, 32'h0000_000F);
    chk_rd(STATUS_ADDR, 32'h0000_000A);
    tdone("rx level");
    i_peer_model.set_idle(2'h2);
    chk_rd(STATUS_ADDR, 32'h0000_002B);
    i_peer_model.set_idle(2'h1);
    chk_rd(STATUS_ADDR, 32'h0000_004B);
    wr(STATUS_ADDR, 32'h0000_0000);
    chk_rd(STATUS_ADDR, 32'h0000_004B);
    wr(TX_FILL_ADDR, 32'h0000_0003);
    chk_rd(TX_FILL_ADDR, 32'h0000_000D);
    chk_rd(32'hB000_2900, 32'h0000_0000);
    tdone("activity and read-only");
    en <= 1'b0;
    chk_rd(STATUS_ADDR, 32'h0000_0047);
    chk_rd(TX_FILL_ADDR, 32'h0000_0000);
    chk_rd(RX_FILL_ADDR, 32'h0000_0000);
    sw(2'h1, 2);
    chk_rd(TX_FILL_ADDR, 32'h0000_0000);
    i_peer_model.set_idle(2'h3);
    chk_rd(STATUS_ADDR, 32'h0000_0006);
    tdone("disable");
    en <= 1'b1;
    sw(2'h1, 5);
    i_peer_model.pulse(5'h04, 1);
    chk_rd(TX_FILL_ADDR, 32'h0000_0000);
    sw(2'h1, 3);
    i_peer_model.pulse(5'h08, 1);
    chk_rd(TX_FILL_ADDR, 32'h0000_0000);
    i_peer_model.pulse(5'h02, 4);
    chk_rd(RX_FILL_ADDR, 32'h0000_0004);
    i_peer_model.pulse(5'h10, 1);
    chk_rd(RX_FILL_ADDR, 32'h0000_0000);
    tdone("aborts");
    chk_rd(EVENT_STATUS_ADDR, 32'h0000_0001);
    irq_is(1'b0);
    wr(EVENT_MASK_ADDR, 32'h0000_0001);
    irq_is(1'b1);
    wr(EVENT_STATUS_ADDR, 32'h0000_0001);
    irq_is(1'b0);
    sw(2'h2, 1);
    chk_rd(EVENT_STATUS_ADDR, 32'h0000_0008);
    tdone("interrupt");
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    chk_rd(EVENT_MASK_ADDR, 32'h0000_0000);
    chk_rd(EVENT_STATUS_ADDR, 32'h0000_0000);
    chk_rd(STATUS_ADDR, 32'h0000_0006);
    chk_rd(TX_FILL_ADDR, 32'h0000_0000);
    tdone("reset again");
    summarize();
  end
endmodule : tb
`default_nettype wire
